//--- hw/cfr_ctrl.sv
`timescale 1ns/10ps
//
// Contract
// - overcurrent fault sets its status bit and uses the overcurrent configuration
// - undercurrent fault sets its status bit and uses its own independent configuration
// - every response value pulls the alert line low and sets the fault bit
// - response 10 switches the output off at once, then restarts per retry count
// - restart attempts number as the retry count in bits 5:3 says
// - retry count 000 makes no restart; output stays off until fault cleared
// - retry count 111 retries forever until commanded off, power lost or other shutdown
// - delay between retries is (retry time field plus one) times 35 ms
module cfr_ctrl #(
  parameter int unsigned RETRY_STEP_CYC = cfr_pkg::RETRY_STEP_CYC
) (
  input  wire  logic             mclk,
  input  wire  logic             reset_n,
  input  wire  logic             lk_clk,
  input  wire  logic             lk_cmd_valid,
  input  wire  cfr_pkg::cfr_cmd_t lk_cmd,
  output logic [7:0]             lk_rdata,
  output logic                   lk_rvalid,
  input  wire  logic             oc_fault_det,
  input  wire  logic             uc_fault_det,
  input  wire  logic             fault_clear,
  input  wire  logic             out_enable_cmd,
  input  wire  logic             ext_shutdown,
  output logic                   output_on,
  output logic [1:0]             fault_status,
  output logic                   alert_line_n
);

  // ----------------------------------------------------------------
  // link domain: command decode and configuration store
  // ----------------------------------------------------------------
  cfr_pkg::cfr_cfg_t    cfg_l_r   [2];
  cfr_pkg::cfr_cfg_t    cfg_l_nxt [2];
  cfr_pkg::cfr_cfg_t    hold_r    [2];
  cfr_pkg::cfr_cfg_t    hold_nxt  [2];
  logic [7:0]           rdata_r;
  logic [7:0]           rdata_nxt;
  logic                 rvalid_r;
  logic                 rvalid_nxt;
  logic                 pend_r;
  logic                 pend_nxt;
  logic                 req_tgl_r;
  logic                 req_tgl_nxt;
  logic                 ack_s1_r;
  logic                 ack_s2_r;
  logic                 ack_tgl_r;

  // decode of a command code to a channel; used by read and write paths
  function automatic logic [1:0] code_hit(input logic [7:0] code);
    code_hit = {code == cfr_pkg::CODE_UC_ACTION, code == cfr_pkg::CODE_OC_ACTION};
  endfunction

  // writes update the store, reads answer one link edge later
  always_comb begin
    logic [1:0] hit;
    hit         = code_hit(lk_cmd.code);
    cfg_l_nxt   = cfg_l_r;
    hold_nxt    = hold_r;
    rdata_nxt   = rdata_r;
    rvalid_nxt  = 1'b0;
    pend_nxt    = pend_r;
    req_tgl_nxt = req_tgl_r;
    if (lk_cmd_valid && lk_cmd.write) begin
      if (hit[0]) cfg_l_nxt[0] = lk_cmd.wdata;
      if (hit[1]) cfg_l_nxt[1] = lk_cmd.wdata;
    end else if (lk_cmd_valid) begin
      rvalid_nxt = 1'b1;
      rdata_nxt  = hit[0] ? cfg_l_r[0] : hit[1] ? cfg_l_r[1] : cfr_pkg::RDATA_UNMAPPED;
    end
    // a new word is launched only once the previous one was acknowledged,
    // so the holding word never changes while the far side samples it
    if (pend_r && (req_tgl_r == ack_s2_r)) begin
      hold_nxt    = cfg_l_r;
      req_tgl_nxt = ~req_tgl_r;
      pend_nxt    = 1'b0;
    end
    if (lk_cmd_valid && lk_cmd.write && (|hit)) pend_nxt = 1'b1;  // set wins
  end

  always_ff @(posedge lk_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_l_r   <= '{cfr_pkg::CFG_RESET, cfr_pkg::CFG_RESET};
      hold_r    <= '{cfr_pkg::CFG_RESET, cfr_pkg::CFG_RESET};
      rdata_r   <= 8'h00;
      rvalid_r  <= 1'b0;
      pend_r    <= 1'b0;
      req_tgl_r <= 1'b0;
      ack_s1_r  <= 1'b0;
      ack_s2_r  <= 1'b0;
    end else begin
      cfg_l_r   <= cfg_l_nxt;
      hold_r    <= hold_nxt;
      rdata_r   <= rdata_nxt;
      rvalid_r  <= rvalid_nxt;
      pend_r    <= pend_nxt;
      req_tgl_r <= req_tgl_nxt;
      ack_s1_r  <= ack_tgl_r;
      ack_s2_r  <= ack_s1_r;
    end
  end

  assign lk_rdata  = rdata_r;
  assign lk_rvalid = rvalid_r;

  // ----------------------------------------------------------------
  // core domain: configuration capture
  // ----------------------------------------------------------------
  cfr_pkg::cfr_cfg_t    cfg_m_r   [2];
  cfr_pkg::cfr_cfg_t    cfg_m_nxt [2];
  logic                 req_s1_r;
  logic                 req_s2_r;
  logic                 req_s3_r;
  logic                 ack_tgl_nxt;

  // hold_r is stable from the toggle until the acknowledge returns
  always_comb begin
    cfg_m_nxt   = cfg_m_r;
    ack_tgl_nxt = ack_tgl_r;
    if (req_s2_r != req_s3_r) begin
      cfg_m_nxt   = hold_r;
      ack_tgl_nxt = req_s2_r;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_m_r   <= '{cfr_pkg::CFG_RESET, cfr_pkg::CFG_RESET};
      req_s1_r  <= 1'b0;
      req_s2_r  <= 1'b0;
      req_s3_r  <= 1'b0;
      ack_tgl_r <= 1'b0;
    end else begin
      cfg_m_r   <= cfg_m_nxt;
      req_s1_r  <= req_tgl_r;
      req_s2_r  <= req_s1_r;
      req_s3_r  <= req_s2_r;
      ack_tgl_r <= ack_tgl_nxt;
    end
  end

  // ----------------------------------------------------------------
  // core domain: fault response per channel (0 overcurrent, 1 undercurrent)
  // ----------------------------------------------------------------
  cfr_pkg::cfr_st_t     st_r      [2];
  cfr_pkg::cfr_st_t     st_nxt    [2];
  logic [2:0]           cnt_r     [2];
  logic [2:0]           cnt_nxt   [2];
  logic [cfr_pkg::TMR_W-1:0] tmr_r   [2];
  logic [cfr_pkg::TMR_W-1:0] tmr_nxt [2];
  logic [1:0]           det;
  logic [1:0]           det_prev_r;
  logic [1:0]           fevt;
  logic [1:0]           stat_r;
  logic [1:0]           stat_nxt;
  logic                 en_prev_r;
  logic                 en_rise;
  logic                 on_r;
  logic                 on_nxt;
  logic                 alert_n_r;
  logic                 alert_n_nxt;

  assign det     = {uc_fault_det, oc_fault_det};
  assign fevt    = det & ~det_prev_r;
  assign en_rise = out_enable_cmd & ~en_prev_r;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ch
      logic                      stop;
      logic [cfr_pkg::TMR_W-1:0] load;
      // retrying ends when commanded off, on outside shutdown, or when the
      // other channel has shut the output down for good
      assign stop = ~out_enable_cmd | ext_shutdown | (st_r[1-gi] == cfr_pkg::CFR_HOLD);
      assign load = cfr_pkg::TMR_W'((32'(cfg_m_r[gi].rtime) + 32'h1) * RETRY_STEP_CYC);

      // each channel reads only its own configuration byte
      always_comb begin
        st_nxt[gi]  = st_r[gi];
        cnt_nxt[gi] = cnt_r[gi];
        tmr_nxt[gi] = tmr_r[gi];
        unique case (st_r[gi])
          cfr_pkg::CFR_RUN: begin
            if (fevt[gi] && cfg_m_r[gi].resp == cfr_pkg::RESP_DIS_RETRY) begin
              if (cfg_m_r[gi].retries == cfr_pkg::RETRY_FOREVER ||
                  cnt_r[gi] < cfg_m_r[gi].retries) begin
                st_nxt[gi]  = cfr_pkg::CFR_WAIT;
                tmr_nxt[gi] = load;
              end else begin
                st_nxt[gi]  = cfr_pkg::CFR_HOLD;
              end
            end else if (fault_clear || en_rise) begin
              cnt_nxt[gi] = 3'h0;
            end
          end
          cfr_pkg::CFR_WAIT: begin
            if (stop) begin
              st_nxt[gi] = cfr_pkg::CFR_HOLD;
            end else if (tmr_r[gi] == cfr_pkg::TMR_W'(1)) begin
              st_nxt[gi] = cfr_pkg::CFR_RUN;
              if (cfg_m_r[gi].retries != cfr_pkg::RETRY_FOREVER)
                cnt_nxt[gi] = cnt_r[gi] + 3'h1;
            end else begin
              tmr_nxt[gi] = tmr_r[gi] - cfr_pkg::TMR_W'(1);
            end
          end
          cfr_pkg::CFR_HOLD: begin
            if (fault_clear || en_rise) begin
              st_nxt[gi]  = cfr_pkg::CFR_RUN;
              cnt_nxt[gi] = 3'h0;
            end
          end
        endcase
      end

      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          st_r[gi]  <= cfr_pkg::CFR_RUN;
          cnt_r[gi] <= 3'h0;
          tmr_r[gi] <= '0;
        end else begin
          st_r[gi]  <= st_nxt[gi];
          cnt_r[gi] <= cnt_nxt[gi];
          tmr_r[gi] <= tmr_nxt[gi];
        end
      end

      sequence s_fault_dr;
        fevt[gi] && st_r[gi] == cfr_pkg::CFR_RUN && cfg_m_r[gi].resp == cfr_pkg::RESP_DIS_RETRY;
      endsequence

      chk_status_set: assert property (@(posedge mclk) disable iff (!reset_n)
        fevt[gi] |=> stat_r[gi] && !alert_line_n)
        else $error("fault event did not set status and alert");
      chk_off_at_once: assert property (@(posedge mclk) disable iff (!reset_n)
        s_fault_dr |=> !output_on && st_r[gi] != cfr_pkg::CFR_RUN)
        else $error("output not switched off on fault");
      chk_no_retry: assert property (@(posedge mclk) disable iff (!reset_n)
        s_fault_dr ##0 cfg_m_r[gi].retries == cfr_pkg::RETRY_NONE
          |=> st_r[gi] == cfr_pkg::CFR_HOLD)
        else $error("zero retry count did not hold output off");
      chk_hold_stays: assert property (@(posedge mclk) disable iff (!reset_n)
        st_r[gi] == cfr_pkg::CFR_HOLD && !fault_clear && !en_rise
          |=> st_r[gi] == cfr_pkg::CFR_HOLD)
        else $error("held channel restarted without clear");
      chk_retry_limit: assert property (@(posedge mclk) disable iff (!reset_n)
        cfg_m_r[gi].retries != cfr_pkg::RETRY_FOREVER && $stable(cfg_m_r[gi].retries)
          |-> cnt_r[gi] <= cfg_m_r[gi].retries || st_r[gi] == cfr_pkg::CFR_RUN)
        else $error("retry count exceeded");
      chk_forever_retry: assert property (@(posedge mclk) disable iff (!reset_n)
        s_fault_dr ##0 cfg_m_r[gi].retries == cfr_pkg::RETRY_FOREVER
          |=> st_r[gi] == cfr_pkg::CFR_WAIT)
        else $error("unlimited retry did not retry");
      chk_retry_delay: assert property (@(posedge mclk) disable iff (!reset_n)
        st_r[gi] == cfr_pkg::CFR_WAIT && $past(st_r[gi]) == cfr_pkg::CFR_RUN
          |-> tmr_r[gi] == cfr_pkg::TMR_W'((32'($past(cfg_m_r[gi].rtime)) + 32'h1) *
                                           RETRY_STEP_CYC))
        else $error("retry delay loaded wrong");
      chk_count_clear: assert property (@(posedge mclk) disable iff (!reset_n)
        (fault_clear || en_rise) && st_r[gi] == cfr_pkg::CFR_HOLD |=> cnt_r[gi] == 3'h0)
        else $error("attempt counter not cleared");
    end
  endgenerate

  // status bits are sticky; a new fault wins over a clear in the same cycle
  always_comb begin
    stat_nxt    = fevt | (stat_r & {2{~fault_clear}});
    alert_n_nxt = ~(|stat_nxt);
    on_nxt      = out_enable_cmd & ~ext_shutdown &
                  (st_nxt[0] == cfr_pkg::CFR_RUN) & (st_nxt[1] == cfr_pkg::CFR_RUN);
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      det_prev_r <= 2'h0;
      en_prev_r  <= 1'b0;
      stat_r     <= 2'h0;
      alert_n_r  <= 1'b1;
      on_r       <= 1'b0;
    end else begin
      det_prev_r <= det;
      en_prev_r  <= out_enable_cmd;
      stat_r     <= stat_nxt;
      alert_n_r  <= alert_n_nxt;
      on_r       <= on_nxt;
    end
  end

  assign fault_status = stat_r;
  assign alert_line_n = alert_n_r;
  assign output_on    = on_r;

  chk_alert_level: assert property (@(posedge mclk) disable iff (!reset_n)
    alert_line_n == !(|fault_status))
    else $error("alert line disagrees with status bits");
  // the alert may only drop because a detector edge was taken one cycle before
  chk_alert_cause: assert property (@(posedge mclk) disable iff (!reset_n)
    $fell(alert_line_n) |-> $past(fevt) != 2'h0)
    else $error("alert line fell without a fault event");
  // a channel already off keeps its state; only a running one is judged here
  chk_uc_own_cfg: assert property (@(posedge mclk) disable iff (!reset_n)
    fevt == 2'h2 && st_r[1] == cfr_pkg::CFR_RUN && cfg_m_r[1].resp != cfr_pkg::RESP_DIS_RETRY
      |=> st_r[1] == cfr_pkg::CFR_RUN)
    else $error("undercurrent acted against its own configuration");

endmodule

//--- hw/cfr_pkg.sv
package cfr_pkg;

  // ----------------------------------------------------------------
  // command codes and configuration layout
  // ----------------------------------------------------------------
  localparam logic [7:0] CODE_OC_ACTION = 8'hE5;
  localparam logic [7:0] CODE_UC_ACTION = 8'hE6;
  localparam logic [7:0] CFG_RESET      = 8'h80;  // disable and retry, no retries, 35 ms
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
  localparam int         RESP_LSB       = 6;
  localparam int         RETRY_LSB      = 3;
  localparam int         RTIME_LSB      = 0;
  localparam logic [1:0] RESP_DIS_RETRY = 2'h2;
  localparam logic [2:0] RETRY_NONE     = 3'h0;
  localparam logic [2:0] RETRY_FOREVER  = 3'h7;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ         = 10_000_000;
  localparam int unsigned RETRY_STEP_MS  = 35;
  localparam int unsigned RETRY_STEP_CYC = RETRY_STEP_MS * (CLK_HZ / 1000);
  localparam int          TMR_W          = 22;     // holds 8 steps of 35 ms

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] resp;
    logic [2:0] retries;
    logic [2:0] rtime;
  } cfr_cfg_t;

  typedef struct packed {
    logic       write;
    logic [7:0] code;
    logic [7:0] wdata;
  } cfr_cmd_t;

  typedef enum logic [1:0] {
    CFR_RUN,
    CFR_WAIT,
    CFR_HOLD
  } cfr_st_t;

endpackage

//--- tb/cfr_host.sv
`timescale 1ns/10ps
// ----
// host on the link port: one byte per command
// ----
module cfr_host (
  input  logic              lk_clk,
  output logic              lk_cmd_valid,
  output cfr_pkg::cfr_cmd_t lk_cmd,
  input  logic [7:0]        lk_rdata,
  input  logic              lk_rvalid
);
  // idle port at time zero
  initial begin
    lk_cmd_valid = 1'b0;
    lk_cmd       = '0;
  end

  // request held over its taking edge; then the lines show the inverse, never a stale copy
  task automatic send(input logic wr, input logic [7:0] code, input logic [7:0] d);
    @(posedge lk_clk);
    lk_cmd_valid <= 1'b1;
    lk_cmd       <= '{write: wr, code: code, wdata: d};
    @(posedge lk_clk);
    lk_cmd_valid <= 1'b0;
    lk_cmd       <= cfr_pkg::cfr_cmd_t'(~lk_cmd);
  endtask

  // single-byte read; gives up after three link cycles
  task automatic rd(input logic [7:0] code, output logic [7:0] d, output bit ok);
    ok = 1'b0;
    d  = 8'h00;
    send(1'b0, code, 8'h00);
    for (int i = 0; i < 3 && !ok; i++) begin
      #1;
      ok = (lk_rvalid === 1'b1);
      d  = lk_rdata;
      if (!ok) @(posedge lk_clk);
    end
  endtask
endmodule

//--- tb/cfr_ctrl_bench.sv
`timescale 1ns/10ps
module cfr_ctrl_bench;
  // short retry step keeps the run small; all retry delays derive from it
  localparam int unsigned STEP = 10;
  logic              mclk, lk_clk, reset_n, lk_cmd_valid, lk_rvalid;
  cfr_pkg::cfr_cmd_t lk_cmd;
  logic [7:0]        lk_rdata;
  logic              oc, uc, fclr, en, shut;
  logic              output_on, alert_line_n;
  logic [1:0]        fault_status;
  int                miscompares = 0;
  int                num_checks  = 0;

  cfr_ctrl #(.RETRY_STEP_CYC(STEP)) cfr_ctrl_inst (
    .mclk(mclk), .reset_n(reset_n), .lk_clk(lk_clk), .lk_cmd_valid(lk_cmd_valid),
    .lk_cmd(lk_cmd), .lk_rdata(lk_rdata), .lk_rvalid(lk_rvalid), .oc_fault_det(oc),
    .uc_fault_det(uc), .fault_clear(fclr), .out_enable_cmd(en), .ext_shutdown(shut),
    .output_on(output_on), .fault_status(fault_status), .alert_line_n(alert_line_n));
  cfr_host cfr_host_inst (
    .lk_clk(lk_clk), .lk_cmd_valid(lk_cmd_valid), .lk_cmd(lk_cmd),
    .lk_rdata(lk_rdata), .lk_rvalid(lk_rvalid));

  // ----
  // clocks: link clock offset so the phases never line up
  // ----
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial begin
    lk_clk = 1'b0;
    #13;
    forever #40 lk_clk = ~lk_clk;
  end

  // ----
  // helpers
  // ----
  task automatic report_and_stop;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // output, status and alert compared as one byte
  task automatic st(input logic on, input logic [1:0] s, input logic a);
    chk({4'h0, output_on, fault_status, alert_line_n}, {4'h0, on, s, a});
  endtask
  task automatic rdchk(input logic [7:0] c, input logic [7:0] e);
    logic [7:0] d;
    bit ok;
    cfr_host_inst.rd(c, d, ok);
    if (!ok) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, 1'b0, 1'b1);
      report_and_stop();
    end
    chk(d, e);
  endtask
  // both bytes written and read back, then time for the crossing to land
  task automatic cfg(input logic [7:0] o, input logic [7:0] u);
    cfr_host_inst.send(1'b1, cfr_pkg::CODE_OC_ACTION, o);
    cfr_host_inst.send(1'b1, cfr_pkg::CODE_UC_ACTION, u);
    rdchk(cfr_pkg::CODE_OC_ACTION, o);
    rdchk(cfr_pkg::CODE_UC_ACTION, u);
    tick(12);
  endtask
  // one-cycle rise on a detector; returns one edge after it is taken
  task automatic fire(input bit u);
    @(posedge mclk);
    if (u) uc <= 1'b1;
    else oc <= 1'b1;
    @(posedge mclk);
    uc <= 1'b0;
    oc <= 1'b0;
    tick(1);
  endtask
  task automatic clear;
    @(posedge mclk);
    fclr <= 1'b1;
    @(posedge mclk);
    fclr <= 1'b0;
    tick(2);
  endtask

  // ----
  // scenarios
  // ----
  task automatic t_regs;
    st(1'b0, 2'h0, 1'b1);
    rdchk(cfr_pkg::CODE_OC_ACTION, cfr_pkg::CFG_RESET);
    cfr_host_inst.send(1'b1, 8'hE7, 8'h55);
    rdchk(8'hE7, cfr_pkg::RDATA_UNMAPPED);
    rdchk(cfr_pkg::CODE_UC_ACTION, cfr_pkg::CFG_RESET);
  endtask
  task automatic t_one_retry;
    cfg(8'h89, 8'h80);
    @(posedge mclk);
    en <= 1'b1;
    tick(3);
    st(1'b1, 2'h0, 1'b1);
    fire(1'b0);
    st(1'b0, 2'h1, 1'b0);
    // fire returns one cycle after the fault was taken; the output is off for the full delay
    tick(2 * STEP - 2);
    st(1'b0, 2'h1, 1'b0);
    tick(1);
    st(1'b1, 2'h1, 1'b0);
    fire(1'b0);
    tick(4 * STEP);
    st(1'b0, 2'h1, 1'b0);
    clear();
    st(1'b1, 2'h0, 1'b1);
    fire(1'b0);
    tick(2 * STEP);
    st(1'b1, 2'h1, 1'b0);
    clear();
  endtask
  task automatic t_no_retry;
    fire(1'b1);
    st(1'b0, 2'h2, 1'b0);
    tick(4 * STEP);
    st(1'b0, 2'h2, 1'b0);
    clear();
    st(1'b1, 2'h0, 1'b1);
  endtask
  task automatic t_forever;
    cfg(8'hB8, 8'h80);
    for (int i = 0; i < 3; i++) begin
      fire(1'b0);
      tick(STEP - 2);
      st(1'b0, 2'h1, 1'b0);
      tick(1);
      st(1'b1, 2'h1, 1'b0);
    end
    fire(1'b0);
    @(posedge mclk);
    shut <= 1'b1;
    tick(3 * STEP);
    st(1'b0, 2'h1, 1'b0);
    @(posedge mclk);
    shut <= 1'b0;
    clear();
    fire(1'b0);
    @(posedge mclk);
    en <= 1'b0;
    tick(3 * STEP);
    st(1'b0, 2'h1, 1'b0);
    @(posedge mclk);
    en <= 1'b1;
    tick(3);
    st(1'b1, 2'h1, 1'b0);
    clear();
  endtask
  // responses other than disable-and-retry only flag the fault
  task automatic t_other_resp;
    logic [1:0] r [3] = '{2'h0, 2'h1, 2'h3};
    for (int i = 0; i < 3; i++) begin
      cfg({r[i], 6'h3F}, {r[i], 6'h00});
      fire(1'b0);
      fire(1'b1);
      st(1'b1, 2'h3, 1'b0);
      clear();
      st(1'b1, 2'h0, 1'b1);
    end
  endtask

  // ----
  // main sequence and watchdog
  // ----
  initial begin
    {reset_n, oc, uc, fclr, en, shut} = '0;
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    tick(2);
    t_regs();
    t_one_retry();
    t_no_retry();
    t_forever();
    t_other_resp();
    report_and_stop();
  end
  initial begin
    #2_000_000;
    miscompares++;
    report_and_stop();
  end
endmodule
